// ### common/fpdc_defines.svh
`ifndef FPDC_DEFINES_SVH
`define FPDC_DEFINES_SVH

`define FPDC_CLK_HZ 64'd250000000
// register offsets
`define FPDC_ADDR_DUTY1 8'h30
`define FPDC_ADDR_DUTY2 8'h31
`define FPDC_ADDR_DUTY3 8'h32
`define FPDC_ADDR_CFG1 8'h5c
`define FPDC_ADDR_CFG2 8'h5d
`define FPDC_ADDR_CFG3 8'h5e
`define FPDC_ADDR_RATE1 8'h5f
`define FPDC_ADDR_RATE2 8'h60
`define FPDC_ADDR_RATE3 8'h61
// reset values
`define FPDC_DUTY_RST 8'hff
`define FPDC_CFG_RST 8'h82
`define FPDC_RATE_RST 8'h04
`define FPDC_RD_NONE 8'h00
// field positions
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_HI 7
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_LO 5
`define FPDC_RATE_HI 2
`define FPDC_RATE_LO 0
`define FPDC_HF_BIT 3
`define FPDC_RATE_USED 8'h0f
// behaviour encodings
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_REM1 3'h0
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_LOCAL 3'h1
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_REM2 3'h2
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_FULL 3'h3
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_OFF 3'h4
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_FAST2 3'h5
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_FAST3 3'h6
`define FPDC_CHANNEL_BEHAVIOUR_SELECT_MANUAL 3'h7
// drive rates in millihertz
`define FPDC_RATE0_MHZ 64'd11000
`define FPDC_RATE1_MHZ 64'd14700
`define FPDC_RATE2_MHZ 64'd22100
`define FPDC_RATE3_MHZ 64'd29400
`define FPDC_RATE4_MHZ 64'd35300
`define FPDC_RATE5_MHZ 64'd44100
`define FPDC_RATE6_MHZ 64'd58800
`define FPDC_RATE7_MHZ 64'd88200
`define FPDC_HF_MHZ 64'd22500000
`define FPDC_STEPS 64'd256
// clock cycles per duty step, one period being 256 steps
`define FPDC_SLOT_CYC(mhz) (64'd1000 * `FPDC_CLK_HZ / (`FPDC_STEPS * (mhz)))
`define FPDC_SLOT_W 17
`define FPDC_DUTY_MIN 8'h00
`define FPDC_DUTY_MAX 8'hff
`define FPDC_ONE8 8'h01
`define FPDC_NCH 3

`endif

// ### common/fpdc_pkg.sv
package fpdc_pkg;
  `include "fpdc_defines.svh"

  typedef enum logic [2:0] {
    FPDC_REM1 = `FPDC_CHANNEL_BEHAVIOUR_SELECT_REM1,
    FPDC_LOCAL = `FPDC_CHANNEL_BEHAVIOUR_SELECT_LOCAL,
    FPDC_REM2 = `FPDC_CHANNEL_BEHAVIOUR_SELECT_REM2,
    FPDC_FULL = `FPDC_CHANNEL_BEHAVIOUR_SELECT_FULL,
    FPDC_OFF = `FPDC_CHANNEL_BEHAVIOUR_SELECT_OFF,
    FPDC_FAST2 = `FPDC_CHANNEL_BEHAVIOUR_SELECT_FAST2,
    FPDC_FAST3 = `FPDC_CHANNEL_BEHAVIOUR_SELECT_FAST3,
    FPDC_MANUAL = `FPDC_CHANNEL_BEHAVIOUR_SELECT_MANUAL
  } fpdc_channel_behaviour_select_t;

  typedef logic [`FPDC_SLOT_W-1:0] fpdc_slot_t;
endpackage : fpdc_pkg

// ### hw/fpdc_pwm_channel.sv
`timescale 1ns/1ns
module fpdc_pwm_channel
  import fpdc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire fpdc_slot_t slotCyc,
  input wire logic [7:0] duty,
  output logic pwmOut
);
  fpdc_slot_t preCnt_r, preCnt_nxt;
  logic [7:0] phase_r, phase_nxt;
  logic [7:0] dutyLat_r, dutyLat_nxt;
  logic pwmOut_nxt;
  logic slotTick;

  always_comb begin
    // >= keeps the prescaler sane when the rate shrinks mid-step
    slotTick = (preCnt_r >= slotCyc - fpdc_slot_t'(1));
    preCnt_nxt = slotTick ? '0 : preCnt_r + fpdc_slot_t'(1);
    phase_nxt = slotTick ? phase_r + `FPDC_ONE8 : phase_r;
    // duty only taken at period start, so no runt pulses
    dutyLat_nxt = (slotTick && phase_r == `FPDC_DUTY_MAX) ? duty : dutyLat_r;
    // full scale held high all period, zero held low all period
    pwmOut_nxt = (dutyLat_r == `FPDC_DUTY_MAX) || (phase_r < dutyLat_r);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      preCnt_r <= '0;
      phase_r <= `FPDC_DUTY_MIN;
      dutyLat_r <= `FPDC_DUTY_RST;
      pwmOut <= 1'b0;
    end else begin
      preCnt_r <= preCnt_nxt;
      phase_r <= phase_nxt;
      dutyLat_r <= dutyLat_nxt;
      pwmOut <= pwmOut_nxt;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_zero_low: assert property ((dutyLat_r == `FPDC_DUTY_MIN) [*2] |-> !pwmOut)
    else $error("zero duty drove the output");
  a_full_high: assert property ((dutyLat_r == `FPDC_DUTY_MAX) [*2] |-> pwmOut)
    else $error("full duty let the output drop");
  a_duty_latch: assert property (slotTick && phase_r == `FPDC_DUTY_MAX |=> dutyLat_r == $past(duty))
    else $error("duty not taken at period start");
endmodule : fpdc_pwm_channel

// ### hw/fpdc_drive_control.sv
`timescale 1ns/1ns
module fpdc_drive_control
  import fpdc_pkg::*;
#(
  parameter fpdc_slot_t LF_SLOT_CYC [8] = '{
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE0_MHZ)),
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE1_MHZ)),
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE2_MHZ)),
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE3_MHZ)),
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE4_MHZ)),
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE5_MHZ)),
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE6_MHZ)),
    fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_RATE7_MHZ))
  }
)
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  input wire logic [7:0] tempReading [3],
  input wire logic [7:0] fanStartTemp [3],
  input wire logic [2:0] rampSpan [3],
  input wire logic [7:0] overtempLimit,
  input wire logic overtempSignal_n,
  input wire logic [7:0] minimumDuty [3],
  input wire logic [7:0] maximumDuty [3],
  input wire logic [2:0] forceToMax,
  input wire logic [2:0] directPower,
  input wire logic [15:0] rampStepCyc,
  output logic [2:0] pwmOut,
  output logic [2:0] tachContinuous
);
  localparam fpdc_slot_t HF_SLOT_CYC = fpdc_slot_t'(`FPDC_SLOT_CYC(`FPDC_HF_MHZ));

  logic [7:0] dutyNow_r [3];
  logic [7:0] dutyNow_nxt [3];
  logic [7:0] swDuty_r [3];
  logic [7:0] swDuty_nxt [3];
  logic [7:0] cfg_r [3];
  logic [7:0] cfg_nxt [3];
  logic [7:0] rate_r [3];
  logic [7:0] rate_nxt [3];
  logic [7:0] rdData_nxt;
  logic [2:0] tachCont_nxt;
  logic [15:0] stepCnt_r, stepCnt_nxt;
  logic stepTick;
  logic thermSync1_r, thermSync2_r;
  logic overtemp;
  logic [7:0] tempDuty [3][3];
  logic [7:0] target [3];
  fpdc_slot_t slotSel [3];
  fpdc_channel_behaviour_select_t channel_behaviour_select [3];

  function automatic logic [7:0] ramp_duty(
    input logic [7:0] temp,
    input logic [7:0] start,
    input logic [2:0] spanK,
    input logic [7:0] minD
  );
    logic [8:0] delta;
    logic [8:0] span;
    logic [15:0] prod;
    logic [7:0] res;
    delta = {1'b0, temp} - {1'b0, start};
    span = 9'(9'd1 << spanK);
    prod = 16'(`FPDC_DUTY_MAX - minD) * 16'(delta[7:0]);
    if (temp <= start) begin
      res = `FPDC_DUTY_MIN;
    end else if (delta >= span) begin
      res = `FPDC_DUTY_MAX;
    end else begin
      // linear between minimum duty and full across the span
      res = minD + 8'(prod >> spanK);
    end
    return res;
  endfunction : ramp_duty

  function automatic logic [7:0] max2(input logic [7:0] a, input logic [7:0] b);
    return (a > b) ? a : b;
  endfunction : max2

  function automatic logic [7:0] addr_of(input int unsigned base, input int unsigned ch);
    return 8'(base + ch);
  endfunction : addr_of

  // overtemperature pin crosses in through two flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      thermSync1_r <= 1'b1;
      thermSync2_r <= 1'b1;
    end else begin
      thermSync1_r <= overtempSignal_n;
      thermSync2_r <= thermSync1_r;
    end
  end

  always_comb begin
    overtemp = !thermSync2_r;
    for (int t = 0; t < `FPDC_NCH; t++) begin
      if (tempReading[t] > overtempLimit) begin
        overtemp = 1'b1;
      end
    end
  end

  // every temperature channel is mapped onto every output with that output's floor
  always_comb begin
    for (int c = 0; c < `FPDC_NCH; c++) begin
      for (int t = 0; t < `FPDC_NCH; t++) begin
        tempDuty[c][t] = ramp_duty(tempReading[t], fanStartTemp[t], rampSpan[t],
                                   minimumDuty[c]);
      end
    end
  end

  // temperature index: 0 remote 1, 1 local, 2 remote 2
  always_comb begin
    for (int c = 0; c < `FPDC_NCH; c++) begin
      channel_behaviour_select[c] = fpdc_channel_behaviour_select_t'(cfg_r[c][`FPDC_CHANNEL_BEHAVIOUR_SELECT_HI:`FPDC_CHANNEL_BEHAVIOUR_SELECT_LO]);
      unique case (channel_behaviour_select[c])
        FPDC_REM1: target[c] = tempDuty[c][0];
        FPDC_LOCAL: target[c] = tempDuty[c][1];
        FPDC_REM2: target[c] = tempDuty[c][2];
        FPDC_FAST2: target[c] = max2(tempDuty[c][1], tempDuty[c][2]);
        FPDC_FAST3: target[c] = max2(tempDuty[c][0], max2(tempDuty[c][1], tempDuty[c][2]));
        FPDC_FULL: target[c] = `FPDC_DUTY_MAX;
        FPDC_OFF: target[c] = `FPDC_DUTY_MIN;
        FPDC_MANUAL: target[c] = swDuty_r[c];
      endcase
    end
  end

  // shared step timer paces how fast automatic duty may move
  always_comb begin
    stepTick = (stepCnt_r >= rampStepCyc);
    stepCnt_nxt = stepTick ? '0 : stepCnt_r + 16'h0001;
  end

  always_comb begin
    for (int c = 0; c < `FPDC_NCH; c++) begin
      cfg_nxt[c] = cfg_r[c];
      rate_nxt[c] = rate_r[c];
      swDuty_nxt[c] = swDuty_r[c];
      dutyNow_nxt[c] = dutyNow_r[c];
      if (regWrEn && regAddr == addr_of(`FPDC_ADDR_CFG1, c)) begin
        cfg_nxt[c] = regWrData;
      end
      if (regWrEn && regAddr == addr_of(`FPDC_ADDR_RATE1, c)) begin
        // only rate field and high-frequency bit exist
        rate_nxt[c] = regWrData & `FPDC_RATE_USED;
      end
      // writes outside manual are dropped silently
      if (regWrEn && regAddr == addr_of(`FPDC_ADDR_DUTY1, c) && channel_behaviour_select[c] == FPDC_MANUAL) begin
        swDuty_nxt[c] = regWrData;
      end
      unique case (channel_behaviour_select[c])
        FPDC_MANUAL: begin
          if (overtemp) begin
            dutyNow_nxt[c] = forceToMax[c] ? maximumDuty[c] : `FPDC_DUTY_MAX;
          end else begin
            dutyNow_nxt[c] = swDuty_nxt[c];
          end
        end
        FPDC_FULL, FPDC_OFF: dutyNow_nxt[c] = target[c];
        FPDC_REM1, FPDC_LOCAL, FPDC_REM2, FPDC_FAST2, FPDC_FAST3: begin
          // automatic: one count per step tick toward the target
          if (stepTick && dutyNow_r[c] < target[c]) begin
            dutyNow_nxt[c] = dutyNow_r[c] + `FPDC_ONE8;
          end else if (stepTick && dutyNow_r[c] > target[c]) begin
            dutyNow_nxt[c] = dutyNow_r[c] - `FPDC_ONE8;
          end
        end
      endcase
    end
  end

  always_comb begin
    rdData_nxt = regRdData;
    if (regRdEn) begin
      rdData_nxt = `FPDC_RD_NONE;
      for (int c = 0; c < `FPDC_NCH; c++) begin
        if (regAddr == addr_of(`FPDC_ADDR_DUTY1, c)) begin
          rdData_nxt = dutyNow_r[c];
        end
        if (regAddr == addr_of(`FPDC_ADDR_CFG1, c)) begin
          rdData_nxt = cfg_r[c];
        end
        if (regAddr == addr_of(`FPDC_ADDR_RATE1, c)) begin
          rdData_nxt = rate_r[c];
        end
      end
    end
    for (int c = 0; c < `FPDC_NCH; c++) begin
      tachCont_nxt[c] = directPower[c] || rate_r[c][`FPDC_HF_BIT];
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < `FPDC_NCH; c++) begin
        dutyNow_r[c] <= `FPDC_DUTY_RST;
        swDuty_r[c] <= `FPDC_DUTY_RST;
        cfg_r[c] <= `FPDC_CFG_RST;
        rate_r[c] <= `FPDC_RATE_RST;
      end
      stepCnt_r <= '0;
      regRdData <= `FPDC_RD_NONE;
      tachContinuous <= '0;
    end else begin
      for (int c = 0; c < `FPDC_NCH; c++) begin
        dutyNow_r[c] <= dutyNow_nxt[c];
        swDuty_r[c] <= swDuty_nxt[c];
        cfg_r[c] <= cfg_nxt[c];
        rate_r[c] <= rate_nxt[c];
      end
      stepCnt_r <= stepCnt_nxt;
      regRdData <= rdData_nxt;
      tachContinuous <= tachCont_nxt;
    end
  end

  for (genvar g = 0; g < `FPDC_NCH; g++) begin : g_chan
    always_comb begin
      // high-frequency bit overrides the rate field entirely
      slotSel[g] = rate_r[g][`FPDC_HF_BIT] ? HF_SLOT_CYC
                 : LF_SLOT_CYC[rate_r[g][`FPDC_RATE_HI:`FPDC_RATE_LO]];
    end
    fpdc_pwm_channel u_chan (
      .core_clk(core_clk),
      .rst_n(rst_n),
      .slotCyc(slotSel[g]),
      .duty(dutyNow_r[g]),
      .pwmOut(pwmOut[g])
    );
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  a_manual_write: assert property (regWrEn && regAddr == `FPDC_ADDR_DUTY1 && channel_behaviour_select[0] == FPDC_MANUAL && !overtemp |=> dutyNow_r[0] == $past(regWrData))
    else $error("manual duty write not applied");
  a_write_ignored: assert property (regWrEn && regAddr == `FPDC_ADDR_DUTY1 && channel_behaviour_select[0] != FPDC_MANUAL |=> swDuty_r[0] == $past(swDuty_r[0]))
    else $error("duty write taken outside manual");
  a_overtemp_force: assert property (channel_behaviour_select[0] == FPDC_MANUAL && overtemp && !forceToMax[0] |=> dutyNow_r[0] == `FPDC_DUTY_MAX)
    else $error("overtemperature did not force full drive");
  a_duty_readback: assert property (regRdEn && regAddr == `FPDC_ADDR_DUTY3 |=> regRdData == $past(dutyNow_r[2]))
    else $error("duty readback differs from applied duty");
  a_hf_tach: assert property (rate_r[0][`FPDC_HF_BIT] |=> tachContinuous[0])
    else $error("high-frequency mode left tach gated");
  a_full_off: assert property (channel_behaviour_select[2] == FPDC_OFF ##1 channel_behaviour_select[2] == FPDC_OFF |-> dutyNow_r[2] == `FPDC_DUTY_MIN)
    else $error("disabled channel not at zero");
  a_auto_slew: assert property (channel_behaviour_select[0] == FPDC_REM1 && $past(channel_behaviour_select[0]) == FPDC_REM1 |-> dutyNow_r[0] == $past(dutyNow_r[0]) || dutyNow_r[0] == $past(dutyNow_r[0]) + `FPDC_ONE8 || dutyNow_r[0] == $past(dutyNow_r[0]) - `FPDC_ONE8)
    else $error("automatic duty moved more than one count");
  a_rate_write: assert property (regWrEn && regAddr == `FPDC_ADDR_RATE1 |=> rate_r[0] == ($past(regWrData) & `FPDC_RATE_USED))
    else $error("rate register write lost");

  c_manual_write: cover property (regWrEn && regAddr == `FPDC_ADDR_DUTY1 && channel_behaviour_select[0] == FPDC_MANUAL);
  c_overtemp: cover property (channel_behaviour_select[1] == FPDC_MANUAL && overtemp);
  c_auto_ramp: cover property (channel_behaviour_select[2] == FPDC_FAST3 && stepTick && dutyNow_r[2] != target[2]);
endmodule : fpdc_drive_control

// ### tb/fpdc_fan_model.sv
`timescale 1ns/1ns
module fpdc_fan_model (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic pwm,
  output logic [31:0] highCyc,
  output logic [31:0] periodCyc,
  output logic [31:0] measCnt
);
  logic [31:0] hiRun;
  logic [31:0] perRun;
  logic pwmLast;
  // the fan times one drive period from rising edge to rising edge
  always @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      {hiRun, perRun, highCyc, periodCyc, measCnt, pwmLast} <= '0;
    end else begin
      pwmLast <= pwm;
      if (pwm && !pwmLast) begin
        highCyc <= hiRun;
        periodCyc <= perRun;
        measCnt <= measCnt + 32'h1;
        hiRun <= 32'h1;
        perRun <= 32'h1;
      end else begin
        hiRun <= hiRun + 32'(pwm);
        perRun <= perRun + 32'h1;
      end
    end
  end
endmodule : fpdc_fan_model

// ### tb/testbench.sv
`timescale 1ns/1ns
`include "fpdc_defines.svh"
module testbench
  import fpdc_pkg::*;
;
  // short slots keep every low-frequency drive period within a few thousand cycles
  localparam fpdc_slot_t SLOT [8] = '{17'h2, 17'h3, 17'h4, 17'h5, 17'h6, 17'h7, 17'h8, 17'h9};
  localparam int HF_SLOT = 43;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic regWrEn, regRdEn, overtempSignal_n;
  logic [7:0] regAddr, regWrData, regRdData, overtempLimit;
  logic [7:0] tempReading [3], fanStartTemp [3], minimumDuty [3], maximumDuty [3];
  logic [2:0] rampSpan [3];
  logic [2:0] forceToMax, directPower, pwmOut, tachContinuous;
  logic [15:0] rampStepCyc;
  logic [31:0] hiC [3], perC [3], mc [3];
  int err_count = 0;
  int n_checks = 0;
  int cyc = 0;

  fpdc_drive_control #(.LF_SLOT_CYC(SLOT)) u_dut (.core_clk(core_clk), .rst_n(rst_n),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regAddr(regAddr), .regWrData(regWrData),
    .regRdData(regRdData), .tempReading(tempReading), .fanStartTemp(fanStartTemp),
    .rampSpan(rampSpan), .overtempLimit(overtempLimit), .overtempSignal_n(overtempSignal_n),
    .minimumDuty(minimumDuty), .maximumDuty(maximumDuty), .forceToMax(forceToMax),
    .directPower(directPower), .rampStepCyc(rampStepCyc), .pwmOut(pwmOut),
    .tachContinuous(tachContinuous));
  for (genvar g = 0; g < 3; g++) begin : g_fan
    fpdc_fan_model u_fan (.core_clk(core_clk), .rst_n(rst_n), .pwm(pwmOut[g]),
      .highCyc(hiC[g]), .periodCyc(perC[g]), .measCnt(mc[g]));
  end

  initial begin
    forever #2 core_clk = ~core_clk;
  end
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 99000) begin
      err_count++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    @(negedge core_clk);
    regWrEn = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge core_clk);
    regAddr = a;
    regRdEn = 1'b1;
    @(negedge core_clk);
    regRdEn = 1'b0;
    @(negedge core_clk);
    d = regRdData;
  endtask : rd

  task automatic rdc(input string nm, input logic [7:0] a, input logic [7:0] e);
    logic [7:0] d;
    rd(a, d);
    chk(nm, d, e);
  endtask : rdc

  // waits n cycles for the new duty to land, then watches n more
  task automatic flat(input int ch, input logic v, input int n);
    int bad;
    bad = 0;
    repeat (n) @(negedge core_clk);
    repeat (n) begin
      @(negedge core_clk);
      if (pwmOut[ch] !== v) bad++;
    end
    chk("flat", bad, 0);
  endtask : flat

  // the first edge may close a period that straddled the change
  task automatic measc(input int ch, input int per, input int hi);
    logic [31:0] m0;
    m0 = mc[ch];
    for (int i = 0; i < 40000 && mc[ch] < m0 + 32'h2; i++) @(posedge core_clk);
    @(negedge core_clk);
    chk("period", perC[ch], 32'(per));
    chk("high", hiC[ch], 32'(hi));
  endtask : measc

  task automatic t_reset();
    for (int i = 0; i < 3; i++) begin
      rdc("duty", `FPDC_ADDR_DUTY1 + 8'(i), 8'h00);
      rdc("cfg", `FPDC_ADDR_CFG1 + 8'(i), 8'h82);
      rdc("rate", `FPDC_ADDR_RATE1 + 8'(i), 8'h04);
    end
    rdc("unmapped", 8'h40, 8'h00);
    wr(`FPDC_ADDR_DUTY1, 8'h55);
    rdc("duty", `FPDC_ADDR_DUTY1, 8'h00);
    flat(0, 1'b0, 1600);
    chk("tach", tachContinuous, 3'h0);
  endtask : t_reset

  task automatic t_manual();
    for (int i = 0; i < 3; i++) wr(`FPDC_ADDR_CFG1 + 8'(i), 8'he2);
    for (int i = 0; i < 3; i++) rdc("duty", `FPDC_ADDR_DUTY1 + 8'(i), 8'hff);
    flat(0, 1'b1, 1600);
    wr(`FPDC_ADDR_DUTY1, 8'h54);
    rdc("duty", `FPDC_ADDR_DUTY1, 8'h54);
    measc(0, 256 * 6, 84 * 6);
    wr(`FPDC_ADDR_DUTY1, 8'h00);
    flat(0, 1'b0, 1600);
    wr(`FPDC_ADDR_DUTY1, 8'h80);
    for (int r = 0; r < 8; r++) begin
      wr(`FPDC_ADDR_RATE1, 8'(r));
      measc(0, 256 * SLOT[r], 128 * SLOT[r]);
    end
  endtask : t_manual

  task automatic t_hf();
    wr(`FPDC_ADDR_RATE1, 8'hfc);
    rdc("rate", `FPDC_ADDR_RATE1, 8'h0c);
    chk("tach", tachContinuous, 3'h1);
    measc(0, 256 * HF_SLOT, 128 * HF_SLOT);
    directPower = 3'h4;
    repeat (2) @(negedge core_clk);
    chk("tach", tachContinuous, 3'h5);
    directPower = 3'h0;
    wr(`FPDC_ADDR_RATE1, 8'h04);
    repeat (2) @(negedge core_clk);
    chk("tach", tachContinuous, 3'h0);
  endtask : t_hf

  task automatic t_over();
    overtempLimit = 8'h50;
    tempReading[0] = 8'h50;
    rdc("duty", `FPDC_ADDR_DUTY1, 8'h80);
    tempReading[0] = 8'h51;
    rdc("duty", `FPDC_ADDR_DUTY1, 8'hff);
    forceToMax = 3'h1;
    rdc("duty", `FPDC_ADDR_DUTY1, 8'hc0);
    tempReading[0] = 8'h28;
    overtempSignal_n = 1'b0;
    repeat (4) @(negedge core_clk);
    rdc("duty", `FPDC_ADDR_DUTY1, 8'hc0);
    overtempSignal_n = 1'b1;
    forceToMax = 3'h0;
    overtempLimit = 8'hff;
    repeat (4) @(negedge core_clk);
    rdc("duty", `FPDC_ADDR_DUTY1, 8'h80);
  endtask : t_over

  task automatic t_auto();
    logic [6:0] hotMask [2];
    logic [7:0] d;
    hotMask = '{7'b1101010, 7'b1001001};
    for (int h = 0; h < 2; h++) begin
      tempReading = '{8'h28, 8'h28, 8'h28};
      tempReading[1 - h] = 8'h38;
      for (int b = 0; b < 7; b++) begin
        wr(`FPDC_ADDR_CFG1, {3'(b), 5'h02});
        wr(`FPDC_ADDR_CFG3, {3'(b), 5'h02});
        repeat (400) @(negedge core_clk);
        rdc("auto1", `FPDC_ADDR_DUTY1, hotMask[h][b] ? 8'hff : 8'h00);
        rdc("auto3", `FPDC_ADDR_DUTY3, hotMask[h][b] ? 8'hff : 8'h00);
      end
    end
    wr(`FPDC_ADDR_CFG1, 8'h22);
    wr(`FPDC_ADDR_DUTY1, 8'h80);
    repeat (400) @(negedge core_clk);
    rdc("duty", `FPDC_ADDR_DUTY1, 8'h00);
    rampStepCyc = 16'h0003;
    tempReading[1] = 8'h38;
    repeat (100) @(negedge core_clk);
    rd(`FPDC_ADDR_DUTY1, d);
    chk("ramp", d > 8'h00 && d < 8'hff, 1);
    repeat (1100) @(negedge core_clk);
    rdc("duty", `FPDC_ADDR_DUTY1, 8'hff);
  endtask : t_auto

  initial begin
    regWrEn = 1'b0;
    regRdEn = 1'b0;
    regAddr = 8'h00;
    regWrData = 8'h00;
    tempReading = '{8'h28, 8'h28, 8'h28};
    fanStartTemp = '{8'h28, 8'h28, 8'h28};
    rampSpan = '{3'h4, 3'h4, 3'h4};
    minimumDuty = '{8'h40, 8'h40, 8'h40};
    maximumDuty = '{8'hc0, 8'hc0, 8'hc0};
    overtempLimit = 8'hff;
    overtempSignal_n = 1'b1;
    forceToMax = 3'h0;
    directPower = 3'h0;
    rampStepCyc = 16'h0000;
    repeat (5) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_manual();
    t_hf();
    t_over();
    t_auto();
    tally_and_finish();
  end
endmodule : testbench
